/* File: logic/host_register_paging_burst.sv */
// Host-visible register bank: paged boot RAM unlock and download, identity words, burst params.
// Assumes host strobes already synchronous to mclk; downloads are carried out by logic outside.
`timescale 1ns/1ps
module host_register_paging_burst
    import host_regs_pkg::*;
#(
    parameter logic [15:0] IDENTITY_VALUE = 16'h5A3C // Arbitrary value.
)
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        small_window,
    input  wire logic        host_write,
    input  wire logic        host_read,
    input  wire logic [16:0] host_address,
    input  wire logic [15:0] host_write_data,
    input  wire logic        download_busy,
    input  wire logic [1:0]  write_pause,
    input  wire logic [1:0]  read_pause,
    output logic      [15:0] host_read_data,
    output logic             host_read_valid,
    output logic             page_load_start,
    output logic             page_load_sequential,
    output logic      [6:0]  page_load_number,
    output logic             serial_fetch_start,
    output logic             write_burst_active,
    output logic             read_burst_enabled,
    output logic             write_burst_enabled,
    output logic      [15:0] write_burst_fields,
    output logic      [15:0] read_burst_fields,
    output logic             download_ready
);
    bus_request_type request;
    assign request = '{host_write, host_read, host_address, host_write_data};

    // Request qualifiers are named once so that decode and checks read the same terms.
    wire       write_cycle    = request.write_strobe;
    wire       read_cycle     = request.read_strobe;
    wire [7:0] write_low_byte = request.write_data[7:0];

    // The communication registers are decoded against their large-window offsets. In the
    // small window they sit 8000H lower, so that distance is folded back in before the
    // compare. The paged RAM registers use the raw address and therefore never move.
    wire [16:0] comm_shift = small_window ? BASE_LARGE_WINDOW : 17'h00000;
    wire [16:0] comm_rel   = 17'(request.address + comm_shift);

    wire hit_unlock  = request.address == OFS_PAGED_RAM_UNLOCK;
    wire hit_choose  = request.address == OFS_PAGE_CHOOSE;
    wire hit_serial  = request.address == OFS_SERIAL_FETCH;
    wire hit_id      = comm_rel == OFS_IDENTITY_WORD;
    wire hit_id_inv  = comm_rel == OFS_IDENTITY_INVERSE;
    wire hit_wburst  = comm_rel == OFS_WRITE_BURST;
    wire hit_rburst  = comm_rel == OFS_READ_BURST;
    wire hit_wleave  = comm_rel == OFS_WRITE_BURST_LEAVE;

    // Only the one command code arms; every other code is reserved and arms nothing.
    wire unlock_code  = write_low_byte == PAGED_UNLOCK_CODE;
    wire unlock_write = write_cycle && hit_unlock && unlock_code;

    logic armed_reg;
    logic armed_next;
    // A read leaves the arming alone; any write consumes it and only 71H re-arms.
    assign armed_next = write_cycle ? unlock_write : armed_reg;

    wire choose_ok = write_cycle && hit_choose && armed_reg;
    wire serial_ok = write_cycle && hit_serial && armed_reg;

    // The sequential flag overrides the page field, so the page number is forced to zero.
    wire       seq_flag    = request.write_data[SEQ_FLAG_BIT];
    wire [6:0] chosen_page = seq_flag ? BOOT_PAGE_ZERO : request.write_data[6:0];

    logic [15:0] wburst_reg;
    logic [15:0] rburst_reg;
    // Both burst registers share one layout, so one masked value feeds either of them.
    wire  [15:0] burst_next  = (request.write_data & BURST_WRITABLE_MASK);
    wire         wburst_load = write_cycle && hit_wburst;
    wire         rburst_load = write_cycle && hit_rburst;
    wire         wleave_load = write_cycle && hit_wleave;
    wire  [15:0] pause_w     = {10'h000, write_pause, 4'h0};
    wire  [15:0] pause_r     = {10'h000, read_pause, 4'h0};

    // Unmapped addresses and reserved bits read 0; no reserved-one bits exist here.
    logic [15:0] read_mux;
    assign read_mux = hit_id     ? IDENTITY_VALUE :
                      hit_id_inv ? ~IDENTITY_VALUE :
                      hit_wburst ? (wburst_reg | pause_w) :
                      hit_rburst ? (rburst_reg | pause_r) :
                      16'h0000;

    // The engine raises its busy flag one cycle after a start pulse, so the pulse itself
    // and the cycle behind it must also hold ready low, or the host would see a false ready.
    wire start_pending = choose_ok || serial_ok || page_load_start || serial_fetch_start;
    wire ready_next    = !download_busy && !start_pending;

    always_ff @(posedge mclk)
    begin
        if (reset)
            armed_reg <= 1'b0;
        else
            armed_reg <= armed_next;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            wburst_reg <= BURST_PARAMS_RESET;
        else if (wburst_load)
            wburst_reg <= burst_next;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            rburst_reg <= BURST_PARAMS_RESET;
        else if (rburst_load)
            rburst_reg <= burst_next;
    end

    // A leave write wins over a simultaneous enable being set.
    always_ff @(posedge mclk)
    begin
        if (reset)
            write_burst_active <= 1'b0;
        else if (wleave_load)
            write_burst_active <= 1'b0;
        else if (wburst_load)
            write_burst_active <= request.write_data[BURST_ENABLE_BIT];
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            page_load_start <= 1'b0;
        else
            page_load_start <= choose_ok;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            page_load_sequential <= 1'b0;
            page_load_number <= BOOT_PAGE_ZERO;
        end
        else if (choose_ok)
        begin
            page_load_sequential <= seq_flag;
            page_load_number <= chosen_page;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            serial_fetch_start <= 1'b0;
        else
            serial_fetch_start <= serial_ok;
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            host_read_data <= 16'h0000;
            host_read_valid <= 1'b0;
        end
        else
        begin
            host_read_valid <= read_cycle;
            host_read_data <= read_cycle ? read_mux : 16'h0000;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
            download_ready <= 1'b0;
        else
            download_ready <= ready_next;
    end

    assign write_burst_enabled = wburst_reg[BURST_ENABLE_BIT];
    assign read_burst_enabled  = rburst_reg[BURST_ENABLE_BIT];
    assign write_burst_fields  = wburst_reg;
    assign read_burst_fields   = rburst_reg;

    a_unlock_arms_choose: assert property (@(posedge mclk) disable iff (reset)
        (request.write_strobe && hit_choose && !armed_reg) |=> !page_load_start)
        else $error("Page select accepted without unlock.");

    // Here the host leaves exactly one idle cycle between the unlock and the select.
    sequence unlock_then_choose;
        unlock_write ##1 !write_cycle ##1 (write_cycle && hit_choose);
    endsequence
    a_choose_starts_load: assert property (@(posedge mclk) disable iff (reset)
        unlock_then_choose |=> page_load_start)
        else $error("Armed page select did not start a load.");

    sequence unlock_then_choose_now;
        unlock_write ##1 (write_cycle && hit_choose);
    endsequence
    a_choose_back_to_back: assert property (@(posedge mclk) disable iff (reset)
        unlock_then_choose_now |=> page_load_start)
        else $error("Back to back page select did not start a load.");

    a_serial_after_unlock: assert property (@(posedge mclk) disable iff (reset)
        serial_fetch_start |-> $past(armed_reg))
        else $error("Serial fetch started without arming.");

    a_serial_refused: assert property (@(posedge mclk) disable iff (reset)
        (write_cycle && hit_serial && !armed_reg) |=> !serial_fetch_start)
        else $error("Serial fetch accepted without unlock.");

    a_serial_starts: assert property (@(posedge mclk) disable iff (reset)
        (write_cycle && hit_serial && armed_reg) |=> serial_fetch_start)
        else $error("Armed serial fetch did not start.");

    a_unlock_sets_arm: assert property (@(posedge mclk) disable iff (reset)
        unlock_write |=> armed_reg)
        else $error("Unlock command did not arm.");

    a_reserved_code_refused: assert property (@(posedge mclk) disable iff (reset)
        (write_cycle && hit_unlock && !unlock_code) |=> !armed_reg)
        else $error("Reserved command code armed the select.");

    a_arming_single_use: assert property (@(posedge mclk) disable iff (reset)
        (armed_reg && request.write_strobe && !unlock_write) |=> !armed_reg)
        else $error("Arming survived a write.");

    a_read_keeps_arm: assert property (@(posedge mclk) disable iff (reset)
        (armed_reg && !request.write_strobe) |=> armed_reg)
        else $error("Read cycle cancelled the arming.");

    a_load_pulse_single: assert property (@(posedge mclk) disable iff (reset)
        page_load_start |=> !page_load_start)
        else $error("Page load start lasted more than one cycle.");

    a_identity_word: assert property (@(posedge mclk) disable iff (reset)
        (read_cycle && hit_id) |=> host_read_data == IDENTITY_VALUE)
        else $error("Identity word wrong.");

    a_identity_inverse: assert property (@(posedge mclk) disable iff (reset)
        (request.read_strobe && hit_id_inv) |=> host_read_data == ~IDENTITY_VALUE)
        else $error("Identity inverse wrong.");

    a_idle_data_zero: assert property (@(posedge mclk) disable iff (reset)
        !read_cycle |=> (host_read_data == 16'h0000 && !host_read_valid))
        else $error("Read data shown without a read.");

    a_burst_reserved_zero: assert property (@(posedge mclk) disable iff (reset)
        (wburst_reg & ~BURST_WRITABLE_MASK) == 16'h0000
        && (rburst_reg & ~BURST_WRITABLE_MASK) == 16'h0000)
        else $error("Reserved burst bits took written data.");

    a_enable_follows: assert property (@(posedge mclk) disable iff (reset)
        (wburst_load && !wleave_load)
        |=> write_burst_active == $past(request.write_data[BURST_ENABLE_BIT]))
        else $error("Burst write enable not taken.");

    a_leave_burst_write: assert property (@(posedge mclk) disable iff (reset)
        (request.write_strobe && hit_wleave) |=> !write_burst_active)
        else $error("Burst write mode not left.");

    a_burst_reset_zero: assert property (@(posedge mclk)
        $fell(reset) |-> (wburst_reg == 16'h0000 && rburst_reg == 16'h0000))
        else $error("Burst registers not zero after reset.");

    a_seq_page_ignored: assert property (@(posedge mclk) disable iff (reset)
        (choose_ok && request.write_data[SEQ_FLAG_BIT]) |=> page_load_number == BOOT_PAGE_ZERO)
        else $error("Page field not ignored in sequential load.");

    a_page_field_taken: assert property (@(posedge mclk) disable iff (reset)
        (choose_ok && !seq_flag) |=> page_load_number == $past(request.write_data[6:0]))
        else $error("Page field not taken in direct load.");

    a_ready_low_on_start: assert property (@(posedge mclk) disable iff (reset)
        (page_load_start || serial_fetch_start) |-> !download_ready ##1 !download_ready)
        else $error("Ready shown while a download was starting.");

    a_busy_blocks_ready: assert property (@(posedge mclk) disable iff (reset)
        download_busy |=> !download_ready)
        else $error("Ready shown while the download engine was busy.");
endmodule : host_register_paging_burst

/* File: logic/host_regs_pkg.sv */
// Shared constants and carrier types for the host register block.
// Assumes a 16-bit memory-mapped host bus with one-cycle write and read strobes.
package host_regs_pkg;
    localparam logic [7:0]  PAGED_UNLOCK_CODE     = 8'h71;
    localparam logic [16:0] OFS_PAGED_RAM_UNLOCK  = 17'h00030;
    localparam logic [16:0] OFS_PAGE_CHOOSE       = 17'h00070;
    localparam logic [16:0] OFS_SERIAL_FETCH      = 17'h00080;
    localparam logic [16:0] BASE_LARGE_WINDOW     = 17'h08000;
    localparam logic [16:0] BASE_SMALL_WINDOW     = 17'h00800;
    localparam logic [16:0] OFS_IDENTITY_WORD     = 17'h09400;
    localparam logic [16:0] OFS_WRITE_BURST       = 17'h09402;
    localparam logic [16:0] OFS_WRITE_BURST_LEAVE = 17'h09404;
    localparam logic [16:0] OFS_IDENTITY_INVERSE  = 17'h09422;
    localparam logic [16:0] OFS_READ_BURST        = 17'h09424;
    localparam logic [15:0] BURST_PARAMS_RESET    = 16'h0000;
    localparam logic [15:0] BURST_WRITABLE_MASK   = 16'h3F02;
    localparam int          SEQ_FLAG_BIT          = 7;
    localparam int          BURST_ENABLE_BIT      = 1;
    localparam logic [6:0]  BOOT_PAGE_ZERO        = 7'h00;

    typedef struct packed {
        logic        write_strobe;
        logic        read_strobe;
        logic [16:0] address;
        logic [15:0] write_data;
    } bus_request_type;

    typedef struct packed {
        logic       start;
        logic       sequential;
        logic [6:0] page;
    } page_load_type;
endpackage : host_regs_pkg

/* File: tb/download_engine_model.sv */
// Download engine model standing behind the paged boot RAM.
// Assumes one-cycle start pulses from the register bank.
`timescale 1ns/1ps
module download_engine_model
#(
    parameter int BUSY_CYCLES = 6
)
(
    input  wire logic mclk,
    input  wire logic reset,
    input  wire logic page_load_start,
    input  wire logic serial_fetch_start,
    output logic      download_busy
);
    int count_reg;
    // A fixed busy span keeps the host polling loop honest without a random engine.
    always_ff @(posedge mclk)
        if (reset) count_reg <= 0;
        else if (page_load_start || serial_fetch_start) count_reg <= BUSY_CYCLES;
        else if (count_reg > 0) count_reg <= count_reg - 1;
    assign download_busy = (count_reg != 0);
endmodule : download_engine_model

/* File: tb/testbench.sv */
// Self-checking bench for the host register bank, with a download engine model.
// Assumes the host strobes are synchronous to mclk.
`timescale 1ns/1ps
module testbench;
    import host_regs_pkg::*;
    localparam logic [15:0] ID = 16'h1E5B; // Arbitrary value.
    logic mclk = 0, reset = 1, small_window = 0, host_write = 0, host_read = 0;
    logic [16:0] host_address = '0;
    logic [15:0] host_write_data = '0, host_read_data, write_burst_fields, read_burst_fields;
    logic [1:0]  write_pause = '0, read_pause = '0;
    logic [6:0]  page_load_number;
    logic download_busy, host_read_valid, page_load_start, page_load_sequential;
    logic serial_fetch_start, write_burst_active, read_burst_enabled, write_burst_enabled;
    logic download_ready;
    int err_total = 0, samples_checked = 0, seed = 30, n;
    logic armed = 0, wa = 0;
    logic [15:0] wb = '0, rb = '0, d;
    host_register_paging_burst #(.IDENTITY_VALUE(ID)) u_host_register_paging_burst (.*);
    download_engine_model u_download_engine_model (.*);
    initial forever #25 mclk = ~mclk;
    task test_done;
        $display("Checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    function logic [16:0] cra(input logic [16:0] ofs);
        return small_window ? ofs - 17'h08000 : ofs;
    endfunction : cra
    task wr(input logic [16:0] a, input logic [15:0] v);
        logic pg, sf;
        pg = armed && a == OFS_PAGE_CHOOSE;
        sf = armed && a == OFS_SERIAL_FETCH;
        armed = (a == OFS_PAGED_RAM_UNLOCK) && v[7:0] == PAGED_UNLOCK_CODE;
        if (a == cra(OFS_WRITE_BURST)) {wb, wa} = {v & BURST_WRITABLE_MASK, v[1]};
        if (a == cra(OFS_READ_BURST)) rb = v & BURST_WRITABLE_MASK;
        if (a == cra(OFS_WRITE_BURST_LEAVE)) wa = 0;
        @(posedge mclk);
        {host_write, host_address, host_write_data} <= {1'b1, a, v};
        @(posedge mclk);
        host_write <= 0;
        #1;
        chk(page_load_start, pg);
        chk(serial_fetch_start, sf);
        chk(write_burst_active, wa);
        if (pg) chk({page_load_sequential, page_load_number}, v[7] ? 8'h80 : v[7:0]);
    endtask : wr
    task rd(input logic [16:0] a, input logic [15:0] exp);
        @(posedge mclk);
        {host_read, host_address} <= {1'b1, a};
        @(posedge mclk);
        host_read <= 0;
        #1;
        chk(host_read_valid, 1);
        chk(host_read_data, exp);
    endtask : rd
    initial
    begin
        #200000 err_total++;
        test_done();
    end
    initial
    begin
        repeat (5) @(posedge mclk);
        {reset, write_pause, read_pause} <= {1'b0, 4'($random(seed))};
        for (int w = 0; w < 2; w++)
        begin
            small_window <= w[0];
            @(posedge mclk);
            rd(cra(OFS_WRITE_BURST), wb | {write_pause, 4'h0});
            rd(cra(OFS_READ_BURST), rb | {read_pause, 4'h0});
            rd(cra(OFS_IDENTITY_WORD), ID);
            rd(cra(OFS_IDENTITY_INVERSE), ~ID);
            rd(cra(17'h09406), 16'h0000);
            repeat (4)
            begin
                d = $random(seed);
                wr(cra(OFS_WRITE_BURST), d); // no burst cycles are run
                wr(cra(OFS_READ_BURST), ~d);
                rd(cra(OFS_WRITE_BURST), wb | {write_pause, 4'h0});
                rd(cra(OFS_READ_BURST), rb | {read_pause, 4'h0});
                chk({write_burst_enabled, read_burst_enabled}, {wb[1], rb[1]});
                chk(write_burst_fields, wb);
                chk(read_burst_fields, rb);
                wr(cra(OFS_WRITE_BURST_LEAVE), ~d);
            end
            wr(OFS_PAGE_CHOOSE, 16'h0000);
            wr(OFS_PAGED_RAM_UNLOCK, 16'h0072);
            wr(OFS_PAGE_CHOOSE, 16'h0000);
            wr(OFS_PAGED_RAM_UNLOCK, 16'h0071);
            wr(OFS_PAGE_CHOOSE, 16'h0000);
            wr(OFS_PAGED_RAM_UNLOCK, 16'h0071);
            wr(OFS_PAGE_CHOOSE, 16'h0080 | 16'($random(seed) & 127));
            wr(OFS_PAGED_RAM_UNLOCK, 16'h0071);
            rd(cra(OFS_IDENTITY_WORD), ID);
            wr(OFS_SERIAL_FETCH, 16'h0000);
            chk(download_ready, 0);
            for (n = 0; n < 100 && download_ready !== 1'b1; n++)
            begin
                @(posedge mclk);
                #1;
            end
            chk(download_ready, 1);
            wr(OFS_PAGED_RAM_UNLOCK, 16'h0071);
            wr(cra(OFS_WRITE_BURST), wb);
            wr(OFS_SERIAL_FETCH, 16'h0000);
        end
        test_done();
    end
endmodule : testbench
